/* latch_unit_pkg.sv */
// Constants shared by the set/reset latch unit and its periodic pulse divider.
// Assumes a single 100 MHz system clock and a 32-bit APB register port.
package latch_unit_pkg;

  // Set and clear source slots
  localparam int unsigned SRC_COUNT = 5;
  localparam int unsigned SRC_SOFT = 0;
  localparam int unsigned SRC_CMP1 = 1;
  localparam int unsigned SRC_CMP2 = 2;
  localparam int unsigned SRC_EXT = 3;
  localparam int unsigned SRC_PERIODIC = 4;

  // Register byte offsets
  localparam logic [7:0] CTRL0_OFFSET = 8'h00;
  localparam logic [7:0] CTRL1_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;

  // latch_control_zero fields
  localparam int unsigned UNIT_ENABLE_BIT = 7;
  localparam int unsigned DIVIDER_LSB = 4;
  localparam int unsigned DIVIDER_WIDTH = 3;
  localparam int unsigned TRUE_PIN_EN_BIT = 3;
  localparam int unsigned INV_PIN_EN_BIT = 2;
  localparam int unsigned SOFT_SET_BIT = 1;
  localparam int unsigned SOFT_CLEAR_BIT = 0;

  // latch_control_one fields
  localparam int unsigned SET_ENABLE_LSB = 0;
  localparam int unsigned CLEAR_ENABLE_LSB = 8;
  localparam int unsigned SYNC_ENABLE_LSB = 16;

  // Status fields
  localparam int unsigned STATUS_LATCH_BIT = 0;
  localparam int unsigned STATUS_SOURCE_LSB = 1;

  // Reset values
  localparam logic [DIVIDER_WIDTH-1:0] DIVIDER_RESET = 3'h0;
  localparam logic [SRC_COUNT-1:0] SET_ENABLE_RESET = 5'h00;
  localparam logic [SRC_COUNT-1:0] CLEAR_ENABLE_RESET = 5'h00;
  localparam logic [1:0] SYNC_ENABLE_RESET = 2'h0;

  // Divide ratio is two to the power of code plus this offset
  localparam int unsigned DIV_EXPONENT_OFFSET = 2;

endpackage

/* divider_if.sv */
// Carrier between the latch unit and its periodic pulse divider.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface divider_if;
  logic [latch_unit_pkg::DIVIDER_WIDTH-1:0] code;
  logic pulse;
  modport source (input code, output pulse);
  modport sink (output code, input pulse);
endinterface

/* periodic_pulse_gen.sv */
// Periodic pulse divider: one-cycle pulse every 2^(code+2) system clocks.
// Assumes code comes from a register in the same clock domain.
`timescale 1ns/1ps
module periodic_pulse_gen #(
  parameter int COUNT_WIDTH = 9
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  divider_if.source link
);

  localparam int MAX_SHIFT =
    (1 << latch_unit_pkg::DIVIDER_WIDTH) - 1 + latch_unit_pkg::DIV_EXPONENT_OFFSET;
  localparam logic [COUNT_WIDTH-1:0] ONE = COUNT_WIDTH'(1);

  generate
    if (COUNT_WIDTH < MAX_SHIFT) begin : g_bad_width
      $error("COUNT_WIDTH too small for largest divide ratio");
    end
  endgenerate

  typedef struct packed {
    logic [COUNT_WIDTH-1:0] count;
    logic pulse;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic [COUNT_WIDTH-1:0] terminal;

  // Largest ratio 512 needs count up to 511
  assign terminal = (ONE << (COUNT_WIDTH'(link.code) +
    COUNT_WIDTH'(latch_unit_pkg::DIV_EXPONENT_OFFSET))) - ONE;

  always_comb begin
    st_d = st_q;
    st_d.pulse = 1'b0;
    // Compare with >= so a ratio lowered mid-count wraps at once
    if (st_q.count >= terminal) begin
      st_d.count = '0;
      st_d.pulse = 1'b1;
    end else begin
      st_d.count = st_q.count + ONE;
    end
    if (i_sys_rst) begin
      st_d = '0;
    end
  end

  always_ff @(posedge i_clock) begin
    st_q <= st_d;
  end

  assign link.pulse = st_q.pulse;

  // Helpers for period checks
  logic [COUNT_WIDTH:0] gap_q;
  logic seen_q;
  logic steady_q;
  logic [latch_unit_pkg::DIVIDER_WIDTH-1:0] code_prev_q;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      gap_q <= '0;
      seen_q <= 1'b0;
      steady_q <= 1'b0;
      code_prev_q <= '0;
    end else begin
      code_prev_q <= link.code;
      gap_q <= st_q.pulse ? (COUNT_WIDTH+1)'(1) : gap_q + (COUNT_WIDTH+1)'(1);
      seen_q <= seen_q | st_q.pulse;
      steady_q <= st_q.pulse | (steady_q & (link.code == code_prev_q));
    end
  end

  property p_pulse_single;
    @(posedge i_clock) disable iff (i_sys_rst)
    st_q.pulse |=> !st_q.pulse;
  endproperty
  a_pulse_single: assert property (p_pulse_single)
    else $error("Periodic pulse wider than one cycle");

  property p_pulse_period;
    @(posedge i_clock) disable iff (i_sys_rst)
    (st_q.pulse && seen_q && steady_q && (link.code == code_prev_q)) |->
      (gap_q == ({1'b0, terminal} + (COUNT_WIDTH+1)'(1)));
  endproperty
  a_pulse_period: assert property (p_pulse_period)
    else $error("Periodic pulse spacing differs from divide ratio");

endmodule

/* set_reset_latch_unit.sv */
// Reset-dominant set/reset latch unit with APB registers and two pin outputs.
// Assumes all inputs synchronous to i_clock; pin direction is set elsewhere.
`timescale 1ns/1ps
module set_reset_latch_unit #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_WIDTH-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_first_comparator_out,
  input wire logic i_second_comparator_out,
  input wire logic i_first_general_timer_tick,
  input wire logic i_external_latch_input,
  output logic o_true_out_pin,
  output logic o_true_out_oe_n,
  output logic o_inverted_out_pin,
  output logic o_inverted_out_oe_n
);

  localparam int unsigned NSRC = latch_unit_pkg::SRC_COUNT;
  localparam int unsigned DW = latch_unit_pkg::DIVIDER_WIDTH;

  generate
    if (ADDR_WIDTH < 4) begin : g_bad_addr
      $error("ADDR_WIDTH must reach the status register");
    end
  endgenerate

  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic unit_en;
    logic [DW-1:0] divider;
    logic true_en;
    logic inv_en;
    logic [NSRC-1:0] set_en;
    logic [NSRC-1:0] clr_en;
    logic [1:0] sync_en;
    logic soft_set;
    logic soft_clr;
    logic [1:0] cmp_held;
    logic latch;
    logic known;
    logic true_pin;
    logic true_oe_n;
    logic inv_pin;
    logic inv_oe_n;
  } state_t;

  localparam state_t STATE_RESET = '{
    divider: latch_unit_pkg::DIVIDER_RESET,
    set_en: latch_unit_pkg::SET_ENABLE_RESET,
    clr_en: latch_unit_pkg::CLEAR_ENABLE_RESET,
    sync_en: latch_unit_pkg::SYNC_ENABLE_RESET,
    true_oe_n: 1'b1,
    inv_oe_n: 1'b1,
    default: '0
  };

  state_t st_q;
  state_t st_d;

  divider_if div_link ();

  periodic_pulse_gen #(
    .COUNT_WIDTH(9)
  ) u_divider (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .link(div_link.source)
  );

  assign div_link.code = st_q.divider;

  logic [1:0] cmp_raw;
  logic [1:0] cmp_synced;
  logic [NSRC-1:0] set_src;
  logic [NSRC-1:0] clr_src;
  logic [NSRC-1:0] set_term;
  logic [NSRC-1:0] clr_term;
  logic set_in;
  logic clr_in;

  assign cmp_raw = {i_second_comparator_out, i_first_comparator_out};

  // Sources differ only in the software slot
  assign set_src = {div_link.pulse, i_external_latch_input, cmp_synced, st_q.soft_set};
  assign clr_src = {div_link.pulse, i_external_latch_input, cmp_synced, st_q.soft_clr};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cmp
      assign cmp_synced[gi] = st_q.sync_en[gi] ? st_q.cmp_held[gi] : cmp_raw[gi];
    end
    for (gi = 0; gi < NSRC; gi++) begin : g_src
      assign set_term[gi] = set_src[gi] & st_q.set_en[gi];
      assign clr_term[gi] = clr_src[gi] & st_q.clr_en[gi];
    end
  endgenerate

  assign set_in = |set_term;
  assign clr_in = |clr_term;

  // APB decode
  logic setup;
  logic done;
  logic hit_ctrl0;
  logic hit_ctrl1;
  logic hit_status;
  logic [31:0] ctrl0_word;
  logic [31:0] ctrl1_word;
  logic [31:0] status_word;

  assign setup = i_psel & ~i_penable;
  assign done = i_psel & i_penable & st_q.ready;
  assign hit_ctrl0 = i_paddr == ADDR_WIDTH'(latch_unit_pkg::CTRL0_OFFSET);
  assign hit_ctrl1 = i_paddr == ADDR_WIDTH'(latch_unit_pkg::CTRL1_OFFSET);
  assign hit_status = i_paddr == ADDR_WIDTH'(latch_unit_pkg::STATUS_OFFSET);

  always_comb begin
    ctrl0_word = '0;
    ctrl0_word[latch_unit_pkg::UNIT_ENABLE_BIT] = st_q.unit_en;
    ctrl0_word[latch_unit_pkg::DIVIDER_LSB +: DW] = st_q.divider;
    ctrl0_word[latch_unit_pkg::TRUE_PIN_EN_BIT] = st_q.true_en;
    ctrl0_word[latch_unit_pkg::INV_PIN_EN_BIT] = st_q.inv_en;
    ctrl0_word[latch_unit_pkg::SOFT_SET_BIT] = st_q.soft_set;
    ctrl0_word[latch_unit_pkg::SOFT_CLEAR_BIT] = st_q.soft_clr;
    ctrl1_word = '0;
    ctrl1_word[latch_unit_pkg::SET_ENABLE_LSB +: NSRC] = st_q.set_en;
    ctrl1_word[latch_unit_pkg::CLEAR_ENABLE_LSB +: NSRC] = st_q.clr_en;
    ctrl1_word[latch_unit_pkg::SYNC_ENABLE_LSB +: 2] = st_q.sync_en;
    status_word = '0;
    status_word[latch_unit_pkg::STATUS_LATCH_BIT] = st_q.latch;
    status_word[latch_unit_pkg::STATUS_SOURCE_LSB +: NSRC] = set_src;
  end

  always_comb begin
    st_d = st_q;
    // Zero-wait slave: ready in the first access cycle
    st_d.ready = setup;
    st_d.slverr = setup & ~(hit_ctrl0 | hit_ctrl1 | hit_status);
    if (setup) begin
      st_d.rdata = hit_ctrl0 ? ctrl0_word :
                   hit_ctrl1 ? ctrl1_word :
                   hit_status ? status_word : 32'h0000_0000;
    end
    // Software pulses last exactly one clock
    st_d.soft_set = 1'b0;
    st_d.soft_clr = 1'b0;
    if (done && i_pwrite && !st_q.slverr) begin
      if (hit_ctrl0) begin
        st_d.unit_en = i_pwdata[latch_unit_pkg::UNIT_ENABLE_BIT];
        st_d.divider = i_pwdata[latch_unit_pkg::DIVIDER_LSB +: DW];
        st_d.true_en = i_pwdata[latch_unit_pkg::TRUE_PIN_EN_BIT];
        st_d.inv_en = i_pwdata[latch_unit_pkg::INV_PIN_EN_BIT];
        st_d.soft_set = i_pwdata[latch_unit_pkg::SOFT_SET_BIT];
        st_d.soft_clr = i_pwdata[latch_unit_pkg::SOFT_CLEAR_BIT];
      end
      if (hit_ctrl1) begin
        st_d.set_en = i_pwdata[latch_unit_pkg::SET_ENABLE_LSB +: NSRC];
        st_d.clr_en = i_pwdata[latch_unit_pkg::CLEAR_ENABLE_LSB +: NSRC];
        st_d.sync_en = i_pwdata[latch_unit_pkg::SYNC_ENABLE_LSB +: 2];
      end
    end
    // Comparator resample on each timer tick
    if (i_first_general_timer_tick) begin
      st_d.cmp_held = cmp_raw;
    end
    // Reset wins over set
    if (clr_in) begin
      st_d.latch = 1'b0;
    end else if (set_in) begin
      st_d.latch = 1'b1;
    end
    if (i_sys_rst) begin
      st_d = STATE_RESET;
      st_d.latch = st_q.latch;
    end
    // Check helper: latch is only defined once an input has driven it
    st_d.known = st_q.known | set_in | clr_in;
    // Pins follow the next latch value so they match the latch each cycle
    st_d.true_oe_n = ~(st_d.unit_en & st_d.true_en);
    st_d.inv_oe_n = ~(st_d.unit_en & st_d.inv_en);
    st_d.true_pin = st_d.latch & ~st_d.true_oe_n;
    st_d.inv_pin = ~st_d.latch & ~st_d.inv_oe_n;
  end

  always_ff @(posedge i_clock) begin
    st_q <= st_d;
  end

  assign o_prdata = st_q.rdata;
  assign o_pready = st_q.ready;
  assign o_pslverr = st_q.slverr;
  assign o_true_out_pin = st_q.true_pin;
  assign o_true_out_oe_n = st_q.true_oe_n;
  assign o_inverted_out_pin = st_q.inv_pin;
  assign o_inverted_out_oe_n = st_q.inv_oe_n;

  sequence s_soft_set_write;
    i_psel && i_penable && st_q.ready && i_pwrite && !st_q.slverr && hit_ctrl0 &&
      i_pwdata[latch_unit_pkg::SOFT_SET_BIT];
  endsequence

  sequence s_one_cycle_set;
    st_q.soft_set ##1 !st_q.soft_set;
  endsequence

  property p_soft_pulse;
    @(posedge i_clock) disable iff (i_sys_rst)
    s_soft_set_write |=> s_one_cycle_set;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse)
    else $error("Software set did not give a one-cycle pulse");

  property p_soft_complete;
    @(posedge i_clock) disable iff (i_sys_rst)
    (s_soft_set_write ##1 (st_q.set_en[latch_unit_pkg::SRC_SOFT] && !clr_in)) |=>
      st_q.latch;
  endproperty
  a_soft_complete: assert property (p_soft_complete)
    else $error("Single software set write did not set the latch");

  property p_reset_dominant;
    @(posedge i_clock) disable iff (i_sys_rst)
    (set_in && clr_in) |=> (!st_q.latch && (o_true_out_oe_n || !o_true_out_pin) &&
      (o_inverted_out_oe_n || o_inverted_out_pin));
  endproperty
  a_reset_dominant: assert property (p_reset_dominant)
    else $error("Simultaneous set and reset did not reset the latch");

  property p_hold;
    @(posedge i_clock) disable iff (i_sys_rst)
    (st_q.known && !set_in && !clr_in) |=> (st_q.latch == $past(st_q.latch));
  endproperty
  a_hold: assert property (p_hold)
    else $error("Latch changed with no active input");

  property p_reset_keeps_latch;
    @(posedge i_clock) disable iff (1'b0)
    (i_sys_rst && st_q.known) |=> (st_q.latch == $past(st_q.latch));
  endproperty
  a_reset_keeps_latch: assert property (p_reset_keeps_latch)
    else $error("System reset altered the latch");

  property p_cmp_held;
    @(posedge i_clock) disable iff (i_sys_rst)
    (st_q.sync_en[0] && !i_first_general_timer_tick) |=>
      (st_q.cmp_held[0] == $past(st_q.cmp_held[0]));
  endproperty
  a_cmp_held: assert property (p_cmp_held)
    else $error("Synchronised comparator changed without a timer tick");

  property p_ext_set;
    @(posedge i_clock) disable iff (i_sys_rst)
    (i_external_latch_input && st_q.set_en[latch_unit_pkg::SRC_EXT] && !clr_in) |=> st_q.latch;
  endproperty
  a_ext_set: assert property (p_ext_set)
    else $error("External input did not set the latch");

  property p_periodic_gated;
    @(posedge i_clock) disable iff (i_sys_rst)
    (div_link.pulse && !st_q.set_en[latch_unit_pkg::SRC_PERIODIC] && !st_q.latch &&
      (set_term == '0)) |=> !st_q.latch;
  endproperty
  a_periodic_gated: assert property (p_periodic_gated)
    else $error("Periodic pulse set the latch while disabled");

  property p_pins_disabled;
    @(posedge i_clock) disable iff (i_sys_rst)
    !st_q.unit_en |-> (o_true_out_oe_n && o_inverted_out_oe_n);
  endproperty
  a_pins_disabled: assert property (p_pins_disabled)
    else $error("Output drove a pin while the unit was disabled");

  property p_both_pins;
    @(posedge i_clock) disable iff (i_sys_rst)
    (st_q.unit_en && st_q.true_en && st_q.inv_en) |->
      (!o_true_out_oe_n && !o_inverted_out_oe_n && (o_true_out_pin != o_inverted_out_pin));
  endproperty
  a_both_pins: assert property (p_both_pins)
    else $error("Both outputs not driven together with opposite levels");

endmodule

/* analog_side_model.sv */
// Far side of the latch unit: comparators, timer tick and external input.
// Assumes the bench commands levels at rising edges; outputs lag one clock.
`timescale 1ns/1ps
module analog_side_model (
  input wire logic i_clock,
  input wire logic i_cmp1_level,
  input wire logic i_cmp2_level,
  input wire logic i_ext_level,
  input wire logic i_tick_request,
  output logic o_first_comparator_out = 1'b0,
  output logic o_second_comparator_out = 1'b0,
  output logic o_external_latch_input = 1'b0,
  output logic o_first_general_timer_tick = 1'b0
);
  // Registered so every change lands just after an edge, like real synced sources
  always @(posedge i_clock) begin
    o_first_comparator_out <= i_cmp1_level;
    o_second_comparator_out <= i_cmp2_level;
    o_external_latch_input <= i_ext_level;
    o_first_general_timer_tick <= i_tick_request;
  end
endmodule

/* tb.sv */
// Self-checking bench for the set/reset latch unit.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin miscompares++; $display("mismatch t=%0t %s", $time, m); end end
module tb;
  localparam logic [7:0] A0 = latch_unit_pkg::CTRL0_OFFSET;
  localparam logic [7:0] A1 = latch_unit_pkg::CTRL1_OFFSET;
  localparam logic [7:0] A2 = latch_unit_pkg::STATUS_OFFSET;
  // Unit enable plus both pin enables
  localparam logic [31:0] C0 = 32'h0000008c;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic cmp1_cmd = 1'b0, cmp2_cmd = 1'b0, ext_cmd = 1'b0, tick_cmd = 1'b0;
  logic cmp1, cmp2, ext, tick, q_pin, q_oe_n, nq_pin, nq_oe_n;
  int miscompares = 0;
  int n_checks = 0;
  // Port direction bit kept by firmware; the pad is pulled high until it is cleared
  logic dir_true = 1'b1;
  logic pad_true;

  assign pad_true = (!q_oe_n && !dir_true) ? q_pin : 1'b1;

  always #5 i_clock = ~i_clock;

  analog_side_model u_analog_side_model (.i_clock(i_clock), .i_cmp1_level(cmp1_cmd),
    .i_cmp2_level(cmp2_cmd), .i_ext_level(ext_cmd), .i_tick_request(tick_cmd),
    .o_first_comparator_out(cmp1), .o_second_comparator_out(cmp2),
    .o_external_latch_input(ext), .o_first_general_timer_tick(tick));

  set_reset_latch_unit u_set_reset_latch_unit (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_first_comparator_out(cmp1), .i_second_comparator_out(cmp2),
    .i_first_general_timer_tick(tick), .i_external_latch_input(ext),
    .o_true_out_pin(q_pin), .o_true_out_oe_n(q_oe_n),
    .o_inverted_out_pin(nq_pin), .o_inverted_out_oe_n(nq_oe_n));

  task automatic wrap_up();
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Request held until pready is seen at a rising edge, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK(pready, 1'b1, "no pready")
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, x, "read data")
    `CHK(e, xe, "read error flag")
  endtask

  // Sampled 1 ns after the edge so registered pins have settled
  task automatic wait_pin(input logic v, input int lim, output int c);
    c = 0;
    do begin
      @(posedge i_clock);
      #1;
      c++;
    end while (q_pin !== v && c < lim);
  endtask

  task automatic chk_pins(input logic q);
    `CHK(q_pin, q, "true pin")
    `CHK(nq_pin, ~q, "inverted pin")
    `CHK({q_oe_n, nq_oe_n}, 2'b00, "pin drive")
    `CHK(pad_true, q, "true pad level")
  endtask

  task automatic lvl(input int s, input logic v);
    @(posedge i_clock);
    case (s)
      1: cmp1_cmd <= v;
      2: cmp2_cmd <= v;
      default: ext_cmd <= v;
    endcase
  endtask

  task automatic t_regs();
    rd_chk(A0, 32'h0, 1'b0);
    rd_chk(A1, 32'h0, 1'b0);
    rd_chk(8'h0c, 32'h0, 1'b1);
    wr(A1, 32'hffffffff);
    rd_chk(A1, 32'h00031f1f, 1'b0);
  endtask

  // Latch starts unknown, so it is cleared before any pin is driven
  task automatic t_init();
    wr(A1, 32'h00000101);
    wr(A0, 32'h00000001);
    rd_chk(A2, 32'h0, 1'b0);
    dir_true <= 1'b0;
    wr(A0, 32'h0000000c);
    repeat (3) @(posedge i_clock);
    #1;
    `CHK({q_oe_n, nq_oe_n}, 2'b11, "pins driven while unit off")
    wr(A0, 32'h00000088);
    repeat (3) @(posedge i_clock);
    #1;
    `CHK({q_oe_n, nq_oe_n, q_pin}, 3'b010, "true pin alone")
    wr(A0, C0);
    repeat (3) @(posedge i_clock);
    #1;
    chk_pins(1'b0);
  endtask

  task automatic t_soft();
    int c;
    wr(A0, C0 | 32'h2);
    wait_pin(1'b1, 6, c);
    chk_pins(1'b1);
    rd_chk(A0, C0, 1'b0);
    rd_chk(A2, 32'h1, 1'b0);
    wr(A0, C0 | 32'h3);
    repeat (4) @(posedge i_clock);
    #1;
    chk_pins(1'b0);
  endtask

  task automatic t_sources();
    int c;
    for (int s = 1; s <= 3; s++) begin
      lvl(s, 1'b1);
      wr(A1, 32'h00000101);
      repeat (4) @(posedge i_clock);
      #1;
      chk_pins(1'b0);
      wr(A1, 32'h00000101 | (32'h1 << s));
      wait_pin(1'b1, 6, c);
      chk_pins(1'b1);
      wr(A1, 32'h00000101 | (32'h1 << s) | (32'h1 << (s + 8)));
      wait_pin(1'b0, 6, c);
      chk_pins(1'b0);
      lvl(s, 1'b0);
    end
  endtask

  // Synced comparator only moves the latch after a timer tick
  task automatic t_sync();
    int c;
    for (int s = 1; s <= 2; s++) begin
      wr(A1, 32'h00000101 | (32'h1 << s) | (32'h1 << (s + 15)));
      lvl(s, 1'b1);
      repeat (8) @(posedge i_clock);
      #1;
      chk_pins(1'b0);
      @(posedge i_clock);
      tick_cmd <= 1'b1;
      @(posedge i_clock);
      tick_cmd <= 1'b0;
      wait_pin(1'b1, 6, c);
      chk_pins(1'b1);
      lvl(s, 1'b0);
      wr(A1, 32'h00000101);
      wr(A0, C0 | 32'h1);
      wait_pin(1'b0, 6, c);
      chk_pins(1'b0);
    end
  endtask

  // External input holds set; the periodic clear punches one-cycle holes
  task automatic t_periodic();
    int c, n;
    wr(A1, 32'h00001109);
    lvl(3, 1'b1);
    for (int k = 0; k < 8; k++) begin
      n = 4 << k;
      wr(A0, C0 | (32'(k) << 4));
      wait_pin(1'b0, 2 * n + 8, c);
      wait_pin(1'b1, 2, c);
      `CHK(c, 1, "pulse width")
      wait_pin(1'b0, n + 8, c);
      `CHK(c, n - 1, "pulse period")
    end
    wr(A1, 32'h00000109);
    wr(A0, C0);
    wait_pin(1'b0, 20, c);
    `CHK(q_pin, 1'b1, "clear without enable")
    lvl(3, 1'b0);
    wr(A1, 32'h00000111);
    wr(A0, C0 | 32'h1);
    wait_pin(1'b0, 6, c);
    wait_pin(1'b1, 12, c);
    `CHK(q_pin, 1'b1, "periodic set")
    wr(A1, 32'h00000101);
  endtask

  // Mid-run reset clears the registers but must leave the set latch alone
  task automatic t_reset();
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    #1;
    `CHK({q_oe_n, nq_oe_n, q_pin, nq_pin}, 4'b1100, "pins after reset")
    rd_chk(A0, 32'h0, 1'b0);
    wr(A0, C0);
    repeat (2) @(posedge i_clock);
    #1;
    chk_pins(1'b1);
  endtask

  initial begin
    repeat (4) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    t_regs();
    t_init();
    t_soft();
    t_sources();
    t_sync();
    t_periodic();
    t_reset();
    wrap_up();
  end

  // Whole run needs well under 10000 cycles
  initial begin
    repeat (40000) @(posedge i_clock);
    miscompares++;
    wrap_up();
  end
endmodule
